// ### hdl/asc_seq_ctrl.sv
// Purpose: Conversion sequence control and status with AXI4-Lite registers.
// Assumes: Raw 10-bit sample present on sample_data when a conversion ends.
// Notes: One write and one read outstanding; unmapped addresses answer SLVERR.
//
// Local design decision: register access over AXI4-Lite.
`include "asc_map.svh"
`default_nettype none

module asc_seq_ctrl #(
    parameter int ADDR_W      = 8,                  // Byte address width
    parameter int CONV_CYCLES = `ASC_CONV_CYCLES    // Cycles per conversion
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output asc_pkg::asc_resp_t       s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output asc_pkg::asc_resp_t       s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [9:0]          sample_data,
    input  wire logic                ext_trigger,
    input  wire logic                special_mode,
    output logic [2:0]               analog_channel,
    output logic                     converting,
    output logic                     irq
);
    import asc_pkg::*;

    localparam int CW = $clog2(CONV_CYCLES + 1);    // Conversion timer width

    // Bus capture
    logic              aw_held;                     // Write address captured
    logic              w_held;                      // Write data captured
    logic [ADDR_W-1:0] aw_addr;                     // Captured write address
    logic [7:0]        w_byte;                      // Captured low data byte
    logic              w_lane;                      // Low byte lane enabled
    logic              wr_fire;                     // Write executes this cycle
    logic              wr_en;                       // Write with low lane on
    logic              rd_fire;                     // Read taken this cycle
    logic [7:0]        wa;                          // Aligned write address
    logic [7:0]        ra;                          // Aligned read address

    // Registers
    logic [7:0]        ctl_two;                     // Fast clear, trigger setup
    logic [7:0]        ctl_three;                   // Length, FIFO mode
    logic [7:0]        ctl_four;                    // Resolution
    logic [7:0]        seq_control;                 // Sequence settings
    logic [7:0]        irq_mask;                    // Interrupt enables
    logic [7:0]        test_value;                  // Test register contents
    logic [7:0]        noise;                       // Free-running scramble
    logic [15:0]       result_q [8];                // Formatted results
    logic [7:0]        conversion_done_flag;        // Per-result done flags
    logic              read_armed;                  // Done-flag read seen
    logic              sequence_done_flag;
    logic              trigger_overrun_flag;
    logic              result_overrun_flag;
    logic [2:0]        conversion_pointer;

    // Sequencer
    asc_state_t        state;
    logic [CW-1:0]     conv_cnt;                    // Cycles into conversion
    logic [3:0]        seq_cnt;                     // Conversions done in sequence
    logic [3:0]        seq_len;                     // Decoded sequence length
    logic              trig_q;                      // Trigger of previous cycle
    logic              trig_rise;
    logic              trig_start;
    logic              trig_ovr_set;
    logic              wr_ctl5;
    logic              abort;
    logic              start_req;
    logic              conv_done;
    logic              seq_last;
    logic              rd_res;                      // Result register read
    logic              rd_done_reg;                 // Done-flag register read
    logic [7:0]        status_byte;
    logic [7:0]        flag_bits;                   // Sticky flags only
    logic [31:0]       next_rdata;
    logic              next_rhit;
    logic              wr_hit;

    // Mapped address check
    function automatic logic asc_mapped(input logic [7:0] a);
        begin
            asc_mapped = (a <= `ASC_OFS_RESULT_LAST);
        end
    endfunction : asc_mapped

    // Result word placement
    function automatic logic [15:0] asc_format(input logic [9:0] raw, input logic low,
                                               input logic right, input logic sgn);
        logic [15:0] w;
        begin
            w = low ? {raw[9:2], 8'h00} : {raw, 6'h00};
            if (right) begin
                w = low ? {8'h00, raw[9:2]} : {6'h00, raw};
            end else if (sgn) begin
                w[15] = ~w[15];
            end
            asc_format = w;
        end
    endfunction : asc_format

    assign wa      = {aw_addr[7:2], 2'b00};
    assign ra      = {s_axi_araddr[7:2], 2'b00};
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_en   = wr_fire && w_lane;
    assign wr_hit  = asc_mapped(wa);
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    // Handshake readies
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // Write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // Write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ASC_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? ASC_OKAY : ASC_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Write decode
    assign wr_ctl5 = wr_en && (wa == `ASC_OFS_SEQ_CTRL);
    assign abort   = wr_en && ((wa == `ASC_OFS_CTL_TWO) || (wa == `ASC_OFS_CTL_THREE)
                               || (wa == `ASC_OFS_CTL_FOUR));

    // Control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_two     <= `ASC_RST_CTL_TWO;
            ctl_three   <= `ASC_RST_CTL_THREE;
            ctl_four    <= `ASC_RST_CTL_FOUR;
            seq_control <= `ASC_RST_SEQ_CTRL;
            irq_mask    <= `ASC_RST_MASK;
        end else if (wr_en) begin
            unique case (wa)
                `ASC_OFS_CTL_TWO:   ctl_two     <= w_byte;
                `ASC_OFS_CTL_THREE: ctl_three   <= w_byte;
                `ASC_OFS_CTL_FOUR:  ctl_four    <= w_byte;
                `ASC_OFS_SEQ_CTRL:  seq_control <= w_byte;
                `ASC_OFS_IRQ_MASK:  irq_mask    <= w_byte;
                default: ;                                  // Others elsewhere or read-only
            endcase
        end
    end

    // Test register and scramble source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            test_value <= 8'h00;
            noise      <= 8'h00;
        end else begin
            noise <= noise + 8'h01;
            if (wr_en && (wa == `ASC_OFS_TEST) && special_mode) begin
                test_value <= w_byte;
            end
        end
    end

    // Sequence length, code zero or eight and up mean full
    assign seq_len = ((ctl_three[`ASC_C3_LEN_HI:`ASC_C3_LEN_LO] == 4'h0)
                      || ctl_three[`ASC_C3_LEN_HI]) ? `ASC_FULL_LEN
                     : ctl_three[`ASC_C3_LEN_HI:`ASC_C3_LEN_LO];

    // Trigger handling
    assign trig_rise    = ext_trigger && !trig_q;
    assign trig_start   = ctl_two[`ASC_C2_TRIG_ENABLE] && (state == ASC_IDLE) && !abort
                          && (ctl_two[`ASC_C2_TRIG_LEVEL] ? ext_trigger : trig_rise);
    assign trig_ovr_set = ctl_two[`ASC_C2_TRIG_ENABLE] && !ctl_two[`ASC_C2_TRIG_LEVEL]
                          && trig_rise && (state == ASC_CONV);
    assign start_req    = wr_ctl5 || trig_start;
    assign conv_done    = (state == ASC_CONV) && !wr_ctl5 && !abort
                          && (conv_cnt == CW'(CONV_CYCLES - 1));
    assign seq_last     = conv_done && (seq_cnt == seq_len - 4'h1);

    // Trigger edge history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= ext_trigger;
        end
    end

    // Sequencer state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ASC_IDLE;
        end else if (wr_ctl5) begin
            state <= ASC_CONV;
        end else if (abort) begin
            state <= ASC_IDLE;
        end else if (trig_start) begin
            state <= ASC_CONV;
        end else if (seq_last && !seq_control[`ASC_SC_SCAN]) begin
            state <= ASC_IDLE;
        end
    end

    // Conversion timer and sequence counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_cnt <= '0;
            seq_cnt  <= 4'h0;
        end else if (start_req || abort) begin
            conv_cnt <= '0;
            seq_cnt  <= 4'h0;
        end else if (conv_done) begin
            conv_cnt <= '0;
            seq_cnt  <= seq_last ? 4'h0 : seq_cnt + 4'h1;
        end else if (state == ASC_CONV) begin
            conv_cnt <= conv_cnt + CW'(1);
        end
    end

    // Channel selection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_channel <= 3'h0;
        end else if (wr_ctl5) begin
            analog_channel <= w_byte[`ASC_SC_CHAN_HI:`ASC_SC_CHAN_LO];
        end else if (trig_start || seq_last) begin
            analog_channel <= seq_control[`ASC_SC_CHAN_HI:`ASC_SC_CHAN_LO];
        end else if (conv_done && seq_control[`ASC_SC_MULTI]) begin
            analog_channel <= analog_channel + 3'h1;
        end
    end

    // Conversion pointer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conversion_pointer <= 3'h0;
        end else if ((start_req || abort) && !ctl_three[`ASC_C3_FIFO]) begin
            conversion_pointer <= 3'h0;
        end else if (seq_last && !ctl_three[`ASC_C3_FIFO]) begin
            conversion_pointer <= 3'h0;
        end else if (conv_done) begin
            conversion_pointer <= conversion_pointer + 3'h1;
        end
    end

    // Result store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 8; i++) begin
                result_q[i] <= 16'h0000;
            end
        end else if (conv_done) begin
            result_q[conversion_pointer] <= asc_format(sample_data,
                ctl_four[`ASC_C4_LOW_RES], seq_control[`ASC_SC_JUSTIFY],
                seq_control[`ASC_SC_SIGNED]);
        end
    end

    // Read classification
    assign rd_res      = rd_fire && (ra >= `ASC_OFS_RESULT_BASE) && (ra <= `ASC_OFS_RESULT_LAST);
    assign rd_done_reg = rd_fire && (ra == `ASC_OFS_CONV_DONE);

    // Done-flag read arms slow result clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            read_armed <= 1'b0;
        end else if (rd_done_reg) begin
            read_armed <= 1'b1;
        end else if (rd_res) begin
            read_armed <= 1'b0;
        end
    end

    // Per-result done flags, control write beats set, set beats read clear
    generate
        for (genvar g = 0; g < 8; g++) begin : g_done
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    conversion_done_flag[g] <= 1'b0;
                end else if (wr_ctl5) begin
                    conversion_done_flag[g] <= 1'b0;
                end else if (conv_done && (conversion_pointer == 3'(g))) begin
                    conversion_done_flag[g] <= 1'b1;
                end else if (rd_res && (ra[4:2] == 3'(g))
                             && (ctl_two[`ASC_C2_FAST_CLEAR] || read_armed)) begin
                    conversion_done_flag[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Sequence done flag, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sequence_done_flag <= 1'b0;
        end else if (seq_last) begin
            sequence_done_flag <= 1'b1;
        end else if ((wr_en && (wa == `ASC_OFS_SEQ_STATUS) && w_byte[`ASC_ST_DONE])
                     || wr_ctl5 || (rd_res && ctl_two[`ASC_C2_FAST_CLEAR])) begin
            sequence_done_flag <= 1'b0;
        end
    end

    // Trigger overrun flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trigger_overrun_flag <= 1'b0;
        end else if (trig_ovr_set) begin
            trigger_overrun_flag <= 1'b1;
        end else if ((wr_en && (wa == `ASC_OFS_SEQ_STATUS) && w_byte[`ASC_ST_TRIG_OVR])
                     || abort || wr_ctl5) begin
            trigger_overrun_flag <= 1'b0;
        end
    end

    // Result overrun flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_overrun_flag <= 1'b0;
        end else if (conv_done && conversion_done_flag[conversion_pointer]) begin
            result_overrun_flag <= 1'b1;
        end else if ((wr_en && (wa == `ASC_OFS_SEQ_STATUS) && w_byte[`ASC_ST_RES_OVR])
                     || start_req) begin
            result_overrun_flag <= 1'b0;
        end
    end

    // Status assembly
    always_comb begin
        status_byte = 8'h00;
        status_byte[`ASC_ST_DONE]     = sequence_done_flag;
        status_byte[`ASC_ST_TRIG_OVR] = trigger_overrun_flag;
        status_byte[`ASC_ST_RES_OVR]  = result_overrun_flag;
        status_byte[`ASC_ST_PTR_HI:`ASC_ST_PTR_LO] = conversion_pointer;
    end

    // Interrupt from masked sticky flags
    assign flag_bits  = status_byte & 8'hb0;
    assign irq        = |(flag_bits & irq_mask);
    assign converting = (state == ASC_CONV);

    // Read data mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rhit  = 1'b1;
        if (rd_res) begin
            next_rdata = {16'h0000, result_q[ra[4:2]]};
        end else begin
            unique case (ra)
                `ASC_OFS_CTL_TWO:    next_rdata = {24'h0, ctl_two};
                `ASC_OFS_CTL_THREE:  next_rdata = {24'h0, ctl_three};
                `ASC_OFS_TEST:       next_rdata = {24'h0, test_value ^ noise};
                `ASC_OFS_SEQ_CTRL:   next_rdata = {24'h0, seq_control};
                `ASC_OFS_CTL_FOUR:   next_rdata = {24'h0, ctl_four};
                `ASC_OFS_SEQ_STATUS: next_rdata = {24'h0, status_byte};
                `ASC_OFS_CONV_DONE:  next_rdata = {24'h0, conversion_done_flag};
                `ASC_OFS_IRQ_MASK:   next_rdata = {24'h0, irq_mask};
                default:             next_rhit  = 1'b0;     // Unmapped
            endcase
        end
    end

    // Read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= ASC_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rhit ? ASC_OKAY : ASC_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : asc_seq_ctrl

`default_nettype wire

// ### include/asc_map.svh
// Purpose: Register map, field positions, reset values for the sequence controller.
// Assumes: 32-bit AXI4-Lite data, one register per aligned word, 8-bit registers except 16-bit results.
// Notes: Included by bare name; definitions only.
//
// Contract
// - Sequence control write aborts and restarts sequence
// - Justify bit one right, zero left
// - Signed only when left justified
// - Result bit placement per resolution and justification
// - Signed result is unsigned with inverted MSB
// - Continuous bit repeats sequences, else single
// - Multi mode increments channel per conversion
// - Channel code selects input, wraps seven to zero
// - Done flag set at each sequence end
// - Done flag cleared by W1C, control write, fast read
// - Edge trigger during sequence sets trigger overrun
// - Trigger overrun cleared by W1C or control writes
// - Result overwrite of unread result sets overrun
// - Result overrun cleared by W1C or sequence start
// - Read-only conversion pointer, status writes ignored
// - Pointer zeroed at sequence edges unless FIFO mode
// - Test register reads unpredictable, writes special only
// - Resolution bit one eight-bit, zero ten-bit
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// Register byte offsets
`define ASC_OFS_CTL_TWO      8'h00
`define ASC_OFS_CTL_THREE    8'h04
`define ASC_OFS_TEST         8'h08
`define ASC_OFS_SEQ_CTRL     8'h0c
`define ASC_OFS_CTL_FOUR     8'h10
`define ASC_OFS_SEQ_STATUS   8'h14
`define ASC_OFS_CONV_DONE    8'h18
`define ASC_OFS_IRQ_MASK     8'h1c
`define ASC_OFS_RESULT_BASE  8'h20
`define ASC_OFS_RESULT_LAST  8'h3c

// Sequence control fields
`define ASC_SC_JUSTIFY       7
`define ASC_SC_SIGNED        6
`define ASC_SC_SCAN          5
`define ASC_SC_MULTI         4
`define ASC_SC_CHAN_HI       2
`define ASC_SC_CHAN_LO       0

// Control two fields
`define ASC_C2_FAST_CLEAR    0
`define ASC_C2_TRIG_LEVEL    1
`define ASC_C2_TRIG_ENABLE   2

// Control three fields
`define ASC_C3_LEN_HI        3
`define ASC_C3_LEN_LO        0
`define ASC_C3_FIFO          4

// Control four fields
`define ASC_C4_LOW_RES       0

// Status fields
`define ASC_ST_DONE          7
`define ASC_ST_TRIG_OVR      5
`define ASC_ST_RES_OVR       4
`define ASC_ST_PTR_HI        2
`define ASC_ST_PTR_LO        0

// Reset values
`define ASC_RST_CTL_TWO      8'h00
`define ASC_RST_CTL_THREE    8'h04
`define ASC_RST_CTL_FOUR     8'h00
`define ASC_RST_SEQ_CTRL     8'h00
`define ASC_RST_MASK         8'h00

// Timing and sizes
`define ASC_CONV_CYCLES      16
`define ASC_FULL_LEN         4'h8

`endif

// ### include/asc_pkg.sv
// Purpose: Types shared by the sequence controller and its bench.
// Assumes: Nothing beyond the map header.
// Notes: Offsets live in asc_map.svh.
`default_nettype none

package asc_pkg;

    // Sequencer state
    typedef enum logic [0:0] {
        ASC_IDLE = 1'b0,
        ASC_CONV = 1'b1
    } asc_state_t;

    // Bus response codes
    typedef enum logic [1:0] {
        ASC_OKAY   = 2'b00,
        ASC_SLVERR = 2'b10
    } asc_resp_t;

endpackage : asc_pkg

`default_nettype wire

// ### test/asc_seq_ctrl_sva.sv
// Purpose: Port checks for the sequence controller.
// Assumes: Write address and data offered together.
// Notes: Bound into every controller instance.
`default_nettype none
module asc_seq_ctrl_sva #(parameter int ADDR_W = 8) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire asc_pkg::asc_resp_t s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [2:0]        analog_channel,
    input wire logic              converting
);
    timeunit 1ns;
    timeprecision 1ps;
    import asc_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Answers stand until taken
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
    // Refusal while answer pending, read answer timing, response code and zero upper data
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rresp_code: assert property ($rose(s_axi_rvalid) |->
        s_axi_rresp == ($past(s_axi_araddr) > 8'h3f ? ASC_SLVERR : ASC_OKAY))
        else $error("wrong read response");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    // Control write restarts on the new channel
    a_seq_restart: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr[7:2] == 6'h03
        |=> ##1 converting && s_axi_bvalid && {29'h0, analog_channel} == ($past(s_axi_wdata, 2) & 32'h7))
        else $error("sequence not restarted");
endmodule : asc_seq_ctrl_sva
bind asc_seq_ctrl asc_seq_ctrl_sva #(.ADDR_W(ADDR_W)) u_sva (.*);
`default_nettype wire

// ### test/tb.sv
// Purpose: Self-checking bench for the sequence controller.
// Assumes: Four-cycle conversions.
// Notes: Seeded xorshift stimulus.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import asc_pkg::*;
    logic aclk = 0, aresetn = 0, ext_trigger = 0, special_mode = 0, use_ch = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, d, seed = 32'h46;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [9:0]  sample_data = 0, raw = 0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic converting, irq;
    wire logic [31:0] s_axi_rdata;
    wire logic [2:0] analog_channel;
    wire asc_resp_t s_axi_bresp, s_axi_rresp;
    asc_resp_t resp;
    int failures = 0, cmp_count = 0, i, k;
    asc_seq_ctrl #(.CONV_CYCLES(4)) uut (.*);
    // Clock and sample source
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) sample_data <= use_ch ? {7'h0, analog_channel} : raw;
    function logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    // Expected result word
    function logic [15:0] fmt(input logic [9:0] r, input logic lo, input logic j, input logic s);
        logic [15:0] v;
        v = lo ? (j ? {8'h0, r[9:2]} : {r[9:2], 8'h0}) : (j ? {6'h0, r} : {r, 6'h0});
        if (!j && s) v[15] = ~v[15];
        return v;
    endfunction : fmt
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        @(negedge aclk);
        while ((s_axi_awready & s_axi_wready) !== 1'b1) @(negedge aclk);
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        @(negedge aclk);
        while (s_axi_bvalid !== 1'b1) @(negedge aclk);
        @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] m);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(negedge aclk);
        while (s_axi_arready !== 1'b1) @(negedge aclk);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(negedge aclk);
        while (s_axi_rvalid !== 1'b1) @(negedge aclk);
        @(posedge aclk);
        d = s_axi_rdata & m;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task wait_idle;
        @(negedge aclk);
        while (converting !== 1'b0) @(negedge aclk);
    endtask : wait_idle
    task give_verdict;
        $display("failures=%0d cmp_count=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict
    // Hang guard
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h14, '1);
        chk(d, 32'h0);
        rd(8'h40, '1);
        chk({d[29:0], resp}, {30'h0, ASC_SLVERR});
        wr(8'h40, 8'h00);
        chk({30'h0, resp}, {30'h0, ASC_SLVERR});
        rd(8'h08, 32'h0);
        chk({30'h0, resp}, {30'h0, ASC_OKAY});
        // All formats, length one
        wr(8'h04, 8'h01);
        for (i = 0; i < 8; i++) begin
            seed = xs(seed);
            raw <= i[0] ? 10'h200 : seed[9:0];
            wr(8'h10, {7'h0, i[2]});
            wr(8'h0c, {i[1], i[0], 6'h0});
            wait_idle();
            rd(8'h20, '1);
            chk(d, {16'h0, fmt(raw, i[2], i[1], i[0])});
            rd(8'h14, '1);
            chk(d, 32'h80);
        end
        // Flag clearing and interrupt
        wr(8'h1c, 8'h80);
        chk({31'h0, irq}, 32'h1);
        wr(8'h14, 8'h07);
        rd(8'h14, '1);
        chk(d, 32'h80);
        wr(8'h14, 8'h80);
        rd(8'h14, '1);
        chk({d[30:0], irq}, 32'h0);
        wr(8'h00, 8'h01);
        wr(8'h0c, 8'h00);
        wait_idle();
        rd(8'h20, '1);
        rd(8'h14, '1);
        chk(d, 32'h0);
        // Multi and single channel, length four
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h04);
        wr(8'h10, 8'h00);
        use_ch <= 1'b1;
        for (i = 0; i < 2; i++) begin
            wr(8'h0c, i ? 8'h85 : 8'h96);
            wait_idle();
            for (k = 0; k < 4; k++) begin
                rd(8'h20 + 8'(4 * k), '1);
                chk(d, i ? 32'h5 : 32'((6 + k) % 8));
            end
        end
        // Continuous run overwrites unread results
        wr(8'h0c, 8'hb6);
        repeat (50) @(posedge aclk);
        rd(8'h14, 32'hb0);
        chk({d[30:0], converting}, 32'h121);
        wr(8'h0c, 8'h80);
        rd(8'h14, 32'hb0);
        chk(d, 32'h0);
        // Edge trigger during a sequence
        wait_idle();
        wr(8'h00, 8'h04);
        for (i = 0; i < 4; i++) begin
            @(posedge aclk);
            ext_trigger <= ~ext_trigger;
        end
        wait_idle();
        rd(8'h14, 32'h20);
        chk(d, 32'h20);
        wr(8'h10, 8'h00);
        rd(8'h14, 32'h20);
        chk(d, 32'h0);
        wr(8'h04, 8'h11);
        wr(8'h0c, 8'h00);
        wait_idle();
        rd(8'h14, 32'h7);
        chk(d, 32'h1);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
